// [bss_pkg.sv]
package bss_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_CMD      = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_SP       = 8'h08;
	localparam logic [7:0] ADDR_SEL      = 8'h0c;
	localparam logic [7:0] ADDR_REG_DATA = 8'h10;
	localparam logic [7:0] ADDR_IO_DATA  = 8'h14;
	localparam logic [7:0] ADDR_ERR      = 8'h18;

	// ==========================================================
	// Command word layout
	localparam int OP_LSB    = 0;
	localparam int OP_W      = 4;
	localparam int REG_LSB   = 4;
	localparam int REG_IDX_W = 4;
	localparam int BIT_LSB   = 8;
	localparam int BIT_IDX_W = 3;
	localparam int IO_LSB    = 12;
	localparam int IO_IDX_W  = 4;

	// ==========================================================
	// Status register flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_T = 6;

	// ==========================================================
	// Error flags, reset values, bus answers
	localparam int         ERR_OVF      = 0;
	localparam int         ERR_UNF      = 1;
	localparam logic [7:0] STATUS_RST   = 8'h00;
	localparam logic [7:0] BYTE_RST     = 8'h00;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// ==========================================================
	// Operation codes
	typedef enum logic [OP_W-1:0] {
		idle_op,
		push_op,
		pop_op,
		io_bit_set_op,
		io_bit_clear_op,
		logical_left_shift_op,
		logical_right_shift_op,
		rotate_left_carry_op,
		rotate_right_carry_op,
		arith_right_shift_op,
		swap_nibble_op,
		flag_set_op,
		flag_clear_op,
		bit_to_transfer_flag_op,
		transfer_flag_to_bit_op
	} bss_op_e;

endpackage

// [bss_bit_write.sv]
`timescale 1ns/1ps
// ==========================================================
// Single bit replace inside a word
module bss_bit_write #(
	parameter int W = 8
) (
	// Word and selector
	input  wire logic [W-1:0]         value,
	input  wire logic [$clog2(W)-1:0] idx,
	input  wire logic                 bit_in,
	// Modified word
	output logic      [W-1:0]         result
);

	// Only the addressed bit moves, neighbours pass through
	always_comb begin
		result      = value;
		result[idx] = bit_in;
	end

endmodule // bss_bit_write

// [bss_shift_unit.sv]
`timescale 1ns/1ps
// ==========================================================
// Shift, rotate and nibble swap datapath
module bss_shift_unit (
	// Operation and operands
	input  wire bss_pkg::bss_op_e op,
	input  wire logic [7:0]       value,
	input  wire logic             carry_in,
	// Result and flags
	output logic      [7:0]       result,
	output logic                  carry_out,
	output logic                  flags_hit
);

	// Carry takes the bit that falls off the end on every shift and rotate; otherwise it passes carry_in [RULE14]
	always_comb begin
		result    = value;
		carry_out = carry_in;
		flags_hit = 1'b1;
		case (op)
			bss_pkg::logical_left_shift_op: begin
				result    = {value[6:0], 1'b0}; // [RULE5]
				carry_out = value[7];
			end
			bss_pkg::logical_right_shift_op: begin
				result    = {1'b0, value[7:1]}; // [RULE6]
				carry_out = value[0];
			end
			bss_pkg::rotate_left_carry_op: begin
				result    = {value[6:0], carry_in}; // [RULE7]
				carry_out = value[7];
			end
			bss_pkg::rotate_right_carry_op: begin
				result    = {carry_in, value[7:1]}; // [RULE8]
				carry_out = value[0];
			end
			bss_pkg::arith_right_shift_op: begin
				result    = {value[7], value[7:1]}; // [RULE9]
				carry_out = value[0];
			end
			bss_pkg::swap_nibble_op: begin
				result    = {value[3:0], value[7:4]}; // [RULE10]
				flags_hit = 1'b0;
			end
			default: begin
				flags_hit = 1'b0;
			end
		endcase
	end

endmodule // bss_shift_unit

// [bss_core.sv]
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Push copies the chosen working register onto the stack.
// RULE2 - Pop loads the chosen working register from the stack top.
// RULE3 - I/O bit set forces one I/O bit high, flags untouched.
// RULE4 - I/O bit clear forces one I/O bit low, flags untouched.
// RULE5 - Left shift moves bits up, zero into bit 0, updates Z C N V.
// RULE6 - Right shift moves bits down, zero into bit 7, updates Z C N V.
// RULE7 - Rotate left: old carry into bit 0, old bit 7 into carry.
// RULE8 - Rotate right: old carry into bit 7, old bit 0 into carry.
// RULE9 - Arithmetic right shift keeps bit 7, shifts the rest down.
// RULE10 - Nibble swap exchanges halves and leaves flags untouched.
// RULE11 - Flag set or clear changes only the selected status bit.
// RULE12 - Bit store copies one source bit into the transfer flag only.
// RULE13 - Bit load copies the transfer flag into one destination bit.
// RULE14 - Carry is the bit shifted out; zero flag marks an all-zero result.
module bss_core #(
	parameter int NREG   = 16,
	parameter int NIO    = 16,
	parameter int DEPTH  = 8,
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// AXI4-Lite write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	// AXI4-Lite read data
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Register contents toward the core
	output logic [NIO*8-1:0]       io_q,
	output logic [7:0]             status_q
);

	// ==========================================================
	// State
	localparam int SPW = $clog2(DEPTH);
	localparam logic [SPW:0] SP_FULL = (SPW+1)'(DEPTH);
	localparam logic [SPW:0] SP_EMPTY = '0;

	typedef struct packed {
		logic                   aw_got;
		logic [ADDR_W-1:0]      aw_addr;
		logic                   w_got;
		logic [31:0]            w_data;
		logic [3:0]             w_strb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic [NREG-1:0][7:0]   wreg;
		logic [NIO-1:0][7:0]    io;
		logic [DEPTH-1:0][7:0]  stack;
		logic [SPW:0]           sp;
		logic [7:0]             status_register;
		logic [7:0]             sel;
		logic                   ovf;
		logic                   unf;
	} bss_state_s;

	bss_state_s state_reg;
	bss_state_s state_next;

	// ==========================================================
	// Command decode from the held write beat
	logic                        wr_fire;
	logic                        ar_fire;
	logic                        cmd_fire;
	logic                        exec;
	bss_pkg::bss_op_e            op;
	logic [bss_pkg::REG_IDX_W-1:0] ri;
	logic [bss_pkg::BIT_IDX_W-1:0] bi;
	logic [bss_pkg::IO_IDX_W-1:0]  ii;
	logic [SPW-1:0]              sp_idx;
	logic [SPW-1:0]              sp_m1;
	logic [7:0]                  dst_val;
	logic [7:0]                  sh_res;
	logic                        sh_c;
	logic                        sh_hit;
	logic [7:0]                  io_bit_res;
	logic [7:0]                  flag_bit_res;
	logic [7:0]                  reg_bit_res;
	logic                        res_n;
	logic                        sel_reg_ok;
	logic                        sel_io_ok;

	// Write is acted on once both halves are held and the answer slot is free
	assign wr_fire  = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
	assign ar_fire  = arvalid && arready;
	assign cmd_fire = wr_fire && (state_reg.aw_addr == bss_pkg::ADDR_CMD)
		&& (state_reg.w_strb[1:0] == 2'h3);
	assign exec     = ce && cmd_fire;
	assign op       = bss_pkg::bss_op_e'(state_reg.w_data[bss_pkg::OP_LSB +: bss_pkg::OP_W]);
	assign ri       = state_reg.w_data[bss_pkg::REG_LSB +: bss_pkg::REG_IDX_W];
	assign bi       = state_reg.w_data[bss_pkg::BIT_LSB +: bss_pkg::BIT_IDX_W];
	assign ii       = state_reg.w_data[bss_pkg::IO_LSB +: bss_pkg::IO_IDX_W];
	assign sp_idx   = state_reg.sp[SPW-1:0];
	assign sp_m1    = sp_idx - SPW'(1);
	assign dst_val  = state_reg.wreg[ri];
	assign res_n    = sh_res[7];
	assign sel_reg_ok = state_reg.sel < 8'(NREG);
	assign sel_io_ok  = state_reg.sel < 8'(NIO);

	// ==========================================================
	// Datapath helpers
	bss_shift_unit u_shift (
		.op        (op),
		.value     (dst_val),
		.carry_in  (state_reg.status_register[bss_pkg::FLAG_C]),
		.result    (sh_res),
		.carry_out (sh_c),
		.flags_hit (sh_hit)
	);

	// I/O bit set or clear
	bss_bit_write #(.W(8)) u_io_bit (
		.value  (state_reg.io[ii]),
		.idx    (bi),
		.bit_in (op == bss_pkg::io_bit_set_op),
		.result (io_bit_res)
	);

	// Status flag set or clear
	bss_bit_write #(.W(8)) u_flag_bit (
		.value  (state_reg.status_register),
		.idx    (bi),
		.bit_in (op == bss_pkg::flag_set_op),
		.result (flag_bit_res)
	);

	// Transfer flag into a working register bit
	bss_bit_write #(.W(8)) u_reg_bit (
		.value  (dst_val),
		.idx    (bi),
		.bit_in (state_reg.status_register[bss_pkg::FLAG_T]),
		.result (reg_bit_res)
	);

	// ==========================================================
	// Handshake outputs; low enable stalls the bus too
	assign awready = ce && !state_reg.aw_got && !state_reg.bvalid;
	assign wready  = ce && !state_reg.w_got && !state_reg.bvalid;
	assign arready = ce && !state_reg.rvalid;

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		// Address and data are taken independently, in either order
		if (awvalid && awready) begin
			state_next.aw_got  = 1'b1;
			state_next.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			state_next.w_got  = 1'b1;
			state_next.w_data = wdata;
			state_next.w_strb = wstrb;
		end
		if (state_reg.bvalid && bready) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.rvalid && rready) begin
			state_next.rvalid = 1'b0;
		end
		// Register writes; a missing low strobe leaves the register alone
		if (wr_fire) begin
			state_next.aw_got = 1'b0;
			state_next.w_got  = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp  = bss_pkg::RESP_OKAY;
			if (state_reg.aw_addr == bss_pkg::ADDR_CMD) begin
				state_next.bresp = bss_pkg::RESP_OKAY;
			end else if (state_reg.aw_addr == bss_pkg::ADDR_STATUS) begin
				if (state_reg.w_strb[0])
					state_next.status_register = state_reg.w_data[7:0];
			end else if (state_reg.aw_addr == bss_pkg::ADDR_SP) begin
				state_next.bresp = bss_pkg::RESP_OKAY; // Read only, write dropped
			end else if (state_reg.aw_addr == bss_pkg::ADDR_SEL) begin
				if (state_reg.w_strb[0])
					state_next.sel = state_reg.w_data[7:0];
			end else if (state_reg.aw_addr == bss_pkg::ADDR_REG_DATA) begin
				if (state_reg.w_strb[0] && sel_reg_ok)
					state_next.wreg[state_reg.sel] = state_reg.w_data[7:0];
			end else if (state_reg.aw_addr == bss_pkg::ADDR_IO_DATA) begin
				if (state_reg.w_strb[0] && sel_io_ok)
					state_next.io[state_reg.sel] = state_reg.w_data[7:0];
			end else if (state_reg.aw_addr == bss_pkg::ADDR_ERR) begin
				// Write one to clear
				if (state_reg.w_strb[0] && state_reg.w_data[bss_pkg::ERR_OVF])
					state_next.ovf = 1'b0;
				if (state_reg.w_strb[0] && state_reg.w_data[bss_pkg::ERR_UNF])
					state_next.unf = 1'b0;
			end else begin
				state_next.bresp = bss_pkg::RESP_SLVERR;
			end
		end
		// Operation execution, one per command write
		if (cmd_fire) begin
			case (op)
				bss_pkg::push_op: begin
					// A full stack drops the push and flags it
					if (state_reg.sp == SP_FULL) begin
						state_next.ovf = 1'b1;
					end else begin
						state_next.stack[sp_idx] = dst_val; // [RULE1]
						state_next.sp = state_reg.sp + (SPW+1)'(1);
					end
				end
				bss_pkg::pop_op: begin
					if (state_reg.sp == SP_EMPTY) begin
						state_next.unf = 1'b1;
					end else begin
						state_next.wreg[ri] = state_reg.stack[sp_m1]; // [RULE2]
						state_next.sp = state_reg.sp - (SPW+1)'(1);
					end
				end
				bss_pkg::io_bit_set_op,
				bss_pkg::io_bit_clear_op: begin
					state_next.io[ii] = io_bit_res; // [RULE3] [RULE4]
				end
				bss_pkg::logical_left_shift_op,
				bss_pkg::logical_right_shift_op,
				bss_pkg::rotate_left_carry_op,
				bss_pkg::rotate_right_carry_op,
				bss_pkg::arith_right_shift_op,
				bss_pkg::swap_nibble_op: begin
					state_next.wreg[ri] = sh_res; // [RULE5] [RULE6] [RULE10]
					// Overflow follows N xor C after any shift
					if (sh_hit) begin
						state_next.status_register[bss_pkg::FLAG_C] = sh_c; // [RULE14]
						state_next.status_register[bss_pkg::FLAG_Z] = (sh_res == 8'h00);
						state_next.status_register[bss_pkg::FLAG_N] = res_n;
						state_next.status_register[bss_pkg::FLAG_V] = res_n ^ sh_c;
					end
				end
				bss_pkg::flag_set_op,
				bss_pkg::flag_clear_op: begin
					state_next.status_register = flag_bit_res; // [RULE11]
				end
				bss_pkg::bit_to_transfer_flag_op: begin
					state_next.status_register[bss_pkg::FLAG_T] = dst_val[bi]; // [RULE12]
				end
				bss_pkg::transfer_flag_to_bit_op: begin
					state_next.wreg[ri] = reg_bit_res; // [RULE13]
				end
				default: begin
					state_next.sel = state_reg.sel;
				end
			endcase
		end
		// Reads answer one cycle after the address is taken
		if (ar_fire) begin
			state_next.rvalid = 1'b1;
			state_next.rresp  = bss_pkg::RESP_OKAY;
			state_next.rdata  = 32'h0000_0000;
			if (araddr == bss_pkg::ADDR_CMD) begin
				state_next.rdata = 32'h0000_0000;
			end else if (araddr == bss_pkg::ADDR_STATUS) begin
				state_next.rdata = {24'h00_0000, state_reg.status_register};
			end else if (araddr == bss_pkg::ADDR_SP) begin
				state_next.rdata = 32'(state_reg.sp);
			end else if (araddr == bss_pkg::ADDR_SEL) begin
				state_next.rdata = {24'h00_0000, state_reg.sel};
			end else if (araddr == bss_pkg::ADDR_REG_DATA) begin
				if (sel_reg_ok)
					state_next.rdata = {24'h00_0000, state_reg.wreg[state_reg.sel]};
			end else if (araddr == bss_pkg::ADDR_IO_DATA) begin
				if (sel_io_ok)
					state_next.rdata = {24'h00_0000, state_reg.io[state_reg.sel]};
			end else if (araddr == bss_pkg::ADDR_ERR) begin
				state_next.rdata = {30'h0000_0000, state_reg.unf, state_reg.ovf};
			end else begin
				state_next.rresp = bss_pkg::RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// Registers; low enable freezes everything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign bvalid   = state_reg.bvalid;
	assign bresp    = state_reg.bresp;
	assign rvalid   = state_reg.rvalid;
	assign rdata    = state_reg.rdata;
	assign rresp    = state_reg.rresp;
	assign io_q     = state_reg.io;
	assign status_q = state_reg.status_register;

	// ==========================================================
	// Checks on operation results
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	push_store_a: assert property ( // [RULE1]
		exec && op == bss_pkg::push_op && state_reg.sp != SP_FULL
		|=> state_reg.stack[$past(sp_idx)] == $past(dst_val)
		&& state_reg.sp == $past(state_reg.sp) + (SPW+1)'(1))
		else $error("push did not store source register");

	pop_load_a: assert property ( // [RULE2]
		exec && op == bss_pkg::pop_op && state_reg.sp != SP_EMPTY
		|=> state_reg.wreg[$past(ri)] == $past(state_reg.stack[sp_m1]))
		else $error("pop did not load destination");

	io_set_a: assert property ( // [RULE3]
		exec && op == bss_pkg::io_bit_set_op
		|=> state_reg.io[$past(ii)] == ($past(state_reg.io[ii]) | (8'h01 << $past(bi)))
		&& $stable(state_reg.status_register))
		else $error("io bit set wrong");

	io_clear_a: assert property ( // [RULE4]
		exec && op == bss_pkg::io_bit_clear_op
		|=> state_reg.io[$past(ii)] == ($past(state_reg.io[ii]) & ~(8'h01 << $past(bi)))
		&& $stable(state_reg.status_register))
		else $error("io bit clear wrong");

	left_shift_a: assert property ( // [RULE5]
		exec && op == bss_pkg::logical_left_shift_op
		|=> state_reg.wreg[$past(ri)] == {$past(dst_val[6:0]), 1'b0}
		&& state_reg.status_register[bss_pkg::FLAG_C] == $past(dst_val[7]))
		else $error("left shift wrong");

	right_shift_a: assert property ( // [RULE6]
		exec && op == bss_pkg::logical_right_shift_op
		|=> state_reg.wreg[$past(ri)] == {1'b0, $past(dst_val[7:1])}
		&& !state_reg.status_register[bss_pkg::FLAG_N])
		else $error("right shift wrong");

	rotate_left_a: assert property ( // [RULE7]
		exec && op == bss_pkg::rotate_left_carry_op
		|=> state_reg.wreg[$past(ri)][0] == $past(state_reg.status_register[bss_pkg::FLAG_C])
		&& state_reg.status_register[bss_pkg::FLAG_C] == $past(dst_val[7]))
		else $error("rotate left wrong");

	rotate_right_a: assert property ( // [RULE8]
		exec && op == bss_pkg::rotate_right_carry_op
		|=> state_reg.wreg[$past(ri)][7] == $past(state_reg.status_register[bss_pkg::FLAG_C])
		&& state_reg.status_register[bss_pkg::FLAG_C] == $past(dst_val[0]))
		else $error("rotate right wrong");

	arith_shift_a: assert property ( // [RULE9]
		exec && op == bss_pkg::arith_right_shift_op
		|=> state_reg.wreg[$past(ri)] == {$past(dst_val[7]), $past(dst_val[7:1])})
		else $error("arithmetic shift wrong");

	nibble_swap_a: assert property ( // [RULE10]
		exec && op == bss_pkg::swap_nibble_op
		|=> state_reg.wreg[$past(ri)] == {$past(dst_val[3:0]), $past(dst_val[7:4])}
		&& $stable(state_reg.status_register))
		else $error("nibble swap wrong");

	flag_edit_a: assert property ( // [RULE11]
		exec && (op == bss_pkg::flag_set_op || op == bss_pkg::flag_clear_op)
		|=> state_reg.status_register[$past(bi)] == ($past(op) == bss_pkg::flag_set_op)
		&& ((state_reg.status_register ^ $past(state_reg.status_register))
		& ~(8'h01 << $past(bi))) == 8'h00)
		else $error("flag edit touched wrong bits");

	bit_store_a: assert property ( // [RULE12]
		exec && op == bss_pkg::bit_to_transfer_flag_op
		|=> state_reg.status_register[bss_pkg::FLAG_T] == $past(dst_val[bi])
		&& state_reg.status_register[5:0] == $past(state_reg.status_register[5:0]))
		else $error("bit store wrong");

	bit_load_a: assert property ( // [RULE13]
		exec && op == bss_pkg::transfer_flag_to_bit_op
		|=> state_reg.wreg[$past(ri)][$past(bi)]
		== $past(state_reg.status_register[bss_pkg::FLAG_T])
		&& $stable(state_reg.status_register))
		else $error("bit load wrong");

	zero_flag_a: assert property ( // [RULE14]
		exec && sh_hit
		|=> state_reg.status_register[bss_pkg::FLAG_Z] == (state_reg.wreg[$past(ri)] == 8'h00))
		else $error("zero flag wrong after shift");

endmodule // bss_core

// [tb_bss_core.sv]
`timescale 1ns/1ps
// ==========================================================
// Bench for the shift, bit and stack operations
module tb_bss_core;
	typedef struct packed {
		logic [3:0] op;
		logic [2:0] b;
		logic [7:0] v;
		logic [7:0] s;
		logic [7:0] r;
		logic [7:0] f;
	} bss_row_s;

	logic          aclk, aresetn, ce;
	logic [7:0]    awaddr, araddr;
	logic          awvalid, wvalid, bready, arvalid, rready;
	logic [31:0]   wdata;
	logic [3:0]    wstrb;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp, resp;
	logic [31:0]   rdata, rd;
	logic [127:0]  io_q;
	logic [7:0]    status_q;
	int            num_errors, samples_checked;
	bss_row_s      rows [13];

	bss_core uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.io_q(io_q), .status_q(status_q));

	// 100 ns period
	always #50 aclk = ~aclk;

	// ==========================================================
	// Compare, verdict and bus tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Readies sampled mid-cycle: they only move at rising edges
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_t, w_t, done;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge aclk);
			aw_t = awvalid & awready;
			w_t = wvalid & wready;
			done = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end
	endtask

	task automatic rdreg(input logic [7:0] a);
		logic ar_t, done;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge aclk);
			ar_t = arvalid & arready;
			done = rvalid;
			rd = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar_t) arvalid <= 1'b0;
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rdreg(a);
		check(rd, exp);
	endtask

	task automatic cmd(input logic [3:0] op, input logic [3:0] r, input logic [2:0] b,
			input logic [3:0] io);
		wr(bss_pkg::ADDR_CMD, {16'h0, io, 1'b0, b, r, op}, 4'hf);
	endtask

	// ==========================================================
	// Hang guard, far above the expected five hundred or so cycles
	initial begin
		repeat (30000) @(posedge aclk);
		num_errors++;
		print_verdict();
	end

	// ==========================================================
	// Main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		ce = 1'b1;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, arvalid} = 3'h0;
		bready = 1'b1;
		rready = 1'b1;
		num_errors = 0;
		samples_checked = 0;
		// Op, bit, value, status in, result, status out
		rows = '{{4'h5, 3'h0, 8'h80, 8'h40, 8'h00, 8'h4b}, {4'h5, 3'h0, 8'h41, 8'h0f, 8'h82, 8'h0c},
			{4'h6, 3'h0, 8'h01, 8'h20, 8'h00, 8'h2b}, {4'h7, 3'h0, 8'h80, 8'h01, 8'h01, 8'h09},
			{4'h8, 3'h0, 8'h01, 8'h01, 8'h80, 8'h05}, {4'h9, 3'h0, 8'h81, 8'h00, 8'hc0, 8'h05},
			{4'ha, 3'h0, 8'h3c, 8'h8f, 8'hc3, 8'h8f}, {4'hb, 3'h7, 8'h5a, 8'h00, 8'h5a, 8'h80},
			{4'hc, 3'h1, 8'h5a, 8'hff, 8'h5a, 8'hfd}, {4'hd, 3'h3, 8'h08, 8'h00, 8'h08, 8'h40},
			{4'hd, 3'h3, 8'hf7, 8'hff, 8'hf7, 8'hbf}, {4'he, 3'h5, 8'h00, 8'h40, 8'h20, 8'h40},
			{4'he, 3'h5, 8'hff, 8'h00, 8'hdf, 8'h00}};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// Table of register and flag operations
		foreach (rows[i]) begin
			wr(bss_pkg::ADDR_SEL, 32'h3, 4'hf);
			wr(bss_pkg::ADDR_REG_DATA, {24'h0, rows[i].v}, 4'hf);
			wr(bss_pkg::ADDR_STATUS, {24'h0, rows[i].s}, 4'hf);
			cmd(rows[i].op, 4'h3, rows[i].b, 4'h0);
			rchk(bss_pkg::ADDR_REG_DATA, {24'h0, rows[i].r});
			check({24'h0, status_q}, {24'h0, rows[i].f});
		end
		// I/O bit set and clear, flags left alone
		wr(bss_pkg::ADDR_SEL, 32'h5, 4'hf);
		wr(bss_pkg::ADDR_STATUS, 32'h3c, 4'hf);
		wr(bss_pkg::ADDR_IO_DATA, 32'h0, 4'hf);
		cmd(4'h3, 4'h0, 3'h7, 4'h5);
		check({24'h0, io_q[47:40]}, 32'h80);
		wr(bss_pkg::ADDR_IO_DATA, 32'hff, 4'hf);
		cmd(4'h4, 4'h0, 3'h0, 4'h5);
		rchk(bss_pkg::ADDR_IO_DATA, 32'hfe);
		check({16'h0, io_q[39:32], status_q}, 32'h3c);
		// Command without both low strobes must not execute
		wr(bss_pkg::ADDR_CMD, 32'h5704, 4'h1);
		check({24'h0, io_q[47:40]}, 32'hfe);
		// Fill the stack, overflow, then drain in reverse order
		for (int i = 0; i < 8; i++) begin
			wr(bss_pkg::ADDR_SEL, i, 4'hf);
			wr(bss_pkg::ADDR_REG_DATA, 32'h10 + i, 4'hf);
			cmd(4'h1, 4'(i), 3'h0, 4'h0);
		end
		cmd(4'h1, 4'h0, 3'h0, 4'h0);
		rchk(bss_pkg::ADDR_ERR, 32'h1);
		rchk(bss_pkg::ADDR_SP, 32'h8);
		wr(bss_pkg::ADDR_SEL, 32'h9, 4'hf);
		for (int i = 7; i >= 0; i--) begin
			cmd(4'h2, 4'h9, 3'h0, 4'h0);
			rchk(bss_pkg::ADDR_REG_DATA, 32'h10 + i);
		end
		cmd(4'h2, 4'h9, 3'h0, 4'h0);
		rchk(bss_pkg::ADDR_ERR, 32'h3);
		wr(bss_pkg::ADDR_ERR, 32'h3, 4'hf);
		rchk(bss_pkg::ADDR_ERR, 32'h0);
		// Unmapped place and read-only count
		wr(8'h1c, 32'h0, 4'hf);
		check({30'h0, resp}, {30'h0, bss_pkg::RESP_SLVERR});
		rchk(8'h1c, 32'h0);
		check({30'h0, resp}, {30'h0, bss_pkg::RESP_SLVERR});
		wr(bss_pkg::ADDR_SP, 32'h5, 4'hf);
		rchk(bss_pkg::ADDR_SP, 32'h0);
		// Clock enable low refuses bus traffic and freezes state
		@(posedge aclk);
		ce <= 1'b0;
		repeat (3) @(negedge aclk);
		check({29'h0, awready, wready, arready}, 32'h0);
		check({24'h0, status_q}, 32'h3c);
		@(posedge aclk);
		ce <= 1'b1;
		// Reset in mid-run clears stack, flags and I/O bits
		cmd(4'h1, 4'h0, 3'h0, 4'h0);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check({24'h0, status_q}, 32'h0);
		check(io_q[31:0] | io_q[63:32] | io_q[95:64] | io_q[127:96], 32'h0);
		rchk(bss_pkg::ADDR_SP, 32'h0);
		print_verdict();
	end
endmodule // tb_bss_core
